// ==== hw/tpic_map.svh ====
`ifndef TPIC_MAP_SVH
`define TPIC_MAP_SVH
// Register offsets
`define TPIC_OFS_CTRL 8'h00
`define TPIC_OFS_DIR 8'h04
`define TPIC_OFS_EDGE 8'h08
`define TPIC_OFS_DDR 8'h0C
`define TPIC_OFS_DATA 8'h10
`define TPIC_OFS_FLAG 8'h14
`define TPIC_OFS_IEN 8'h18
`define TPIC_OFS_COUNT 8'h1C
`define TPIC_OFS_CAP 8'h20
`define TPIC_OFS_CAPH 8'h40
`define TPIC_OFS_CAPL 8'h60
// Control fields
`define TPIC_CTRL_RUN 0
`define TPIC_CTRL_FFCA 1
`define TPIC_CTRL_PSEL_LSB 2
`define TPIC_CTRL_PSEL_MSB 4
`define TPIC_PSEL_MAX 3'h5
// Reset values
`define TPIC_RST_CTRL 5'h00
`define TPIC_RST_BYTE 8'h00
`define TPIC_RST_EDGE 16'h0000
// Bus answers
`define TPIC_RESP_OKAY 2'h0
`define TPIC_RESP_SLVERR 2'h2
`endif

// ==== hw/tpic_pkg.sv ====
`default_nettype none
package tpic_pkg;
   typedef enum logic [1:0] {
      TPIC_EDGE_NONE = 2'h0,
      TPIC_EDGE_RISE = 2'h1,
      TPIC_EDGE_FALL = 2'h2,
      TPIC_EDGE_BOTH = 2'h3
   } tpic_edge_e;
   typedef struct packed {
      logic [2:0] psel;
      logic ffca;
      logic run;
   } tpic_ctrl_s;
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } tpic_rd_s;
endpackage
`default_nettype wire

// ==== hw/tpic_top.sv ====
// Contract
// [RULE1] Counter tick comes from module clock through divider of 1 to 32.
// [RULE2] Prescale code 000 divides by one, each next code doubles, up to 32.
// [RULE3] A channel whose direction select bit is zero works as input capture.
// [RULE4] Active pin edge copies the full 16-bit counter into the capture register.
// [RULE5] After a high-byte read the low byte stays held for the next bus read.
// [RULE6] External pulses must last longer than two module clocks to be caught.
// [RULE7] Capture mode never changes pin direction; only the port direction bits do.
// [RULE8] On an input pin, outside edges trigger captures.
// [RULE9] On an output pin, edges of the driven value still trigger captures.
// [RULE10] Each capture sets the channel event flag.
// [RULE11] Interrupt asks only while a flag and its enable are both set.
// [RULE12] Per channel edge select: none, rising, falling, both; none after reset.
// [RULE13] With fast clear set, reading a capture clears that channel's flag.
// [RULE14] With run enable clear, prescaler and counter stand still.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`include "tpic_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tpic_top #(
   parameter int NCH = 8,
   parameter int CW = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] cap_pin,
   output logic [NCH-1:0] pin_out,
   output logic [NCH-1:0] pin_oe,
   output logic irq
);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Register state
   tpic_pkg::tpic_ctrl_s ctrl_q;
   logic [NCH-1:0] dir_q;
   logic [2*NCH-1:0] edge_q;
   logic [NCH-1:0] ddr_q;
   logic [NCH-1:0] data_q;
   logic [NCH-1:0] flag_q;
   logic [NCH-1:0] ien_q;
   logic [4:0] div_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] cap_q [NCH];
   logic [7:0] low_view_q [NCH];
   logic [NCH-1:0] low_hold_q;

   // Write channel state
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // Pin sync and edge state
   logic [NCH-1:0] sync1_q;
   logic [NCH-1:0] sync2_q;
   logic [NCH-1:0] sync3_q;
   logic [NCH-1:0] filt_q;
   logic [NCH-1:0] src_prev_q;
   logic [NCH-1:0] src;
   logic [NCH-1:0] cap_ev;

   logic aw_hs;
   logic w_hs;
   logic wr_go;
   logic ar_hs;
   logic tick;
   logic [4:0] div_last;
   logic [31:0] merged;
   logic [31:0] m_dir;
   logic [31:0] m_edge;
   logic [31:0] m_ddr;
   logic [31:0] m_data;
   logic [31:0] m_ien;
   tpic_pkg::tpic_rd_s rd;
   logic [NCH-1:0] rd_clr;
   logic [NCH-1:0] hi_rd;
   logic [2:0] rch;

   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign merged = merge(32'h00000000, wdata_q, wstrb_q);
   assign m_dir = merge(32'(dir_q), wdata_q, wstrb_q);
   assign m_edge = merge(32'(edge_q), wdata_q, wstrb_q);
   assign m_ddr = merge(32'(ddr_q), wdata_q, wstrb_q);
   assign m_data = merge(32'(data_q), wdata_q, wstrb_q);
   assign m_ien = merge(32'(ien_q), wdata_q, wstrb_q);
   assign rch = s_axi_araddr[4:2];

   // Prescaler
   always_comb begin
      case (ctrl_q.psel)
         3'h0: div_last = 5'h00;
         3'h1: div_last = 5'h01;
         3'h2: div_last = 5'h03;
         3'h3: div_last = 5'h07;
         3'h4: div_last = 5'h0F;
         default: div_last = 5'h1F;
      endcase
   end
   assign tick = ctrl_q.run && (div_q >= div_last); // [RULE1] [RULE2] [RULE14]

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 5'h00;
      end else if (!ctrl_q.run) begin
         div_q <= div_q; // [RULE14]
      end else if (tick) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01; // [RULE1]
      end
   end

   // Free-running counter
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else if (tick) begin
         count_q <= count_q + CW'(1); // [RULE14]
      end
   end

   // Pin synchroniser and agreement filter
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         filt_q <= '0;
      end else begin
         sync1_q <= cap_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q)); // [RULE6]
      end
   end

   // Edge source follows pin direction
   assign src = (ddr_q & data_q) | (~ddr_q & filt_q); // [RULE8] [RULE9]

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_prev_q <= '0;
      end else begin
         src_prev_q <= src;
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         logic rise;
         logic fall;
         rise = src[i] && !src_prev_q[i];
         fall = !src[i] && src_prev_q[i];
         case (tpic_pkg::tpic_edge_e'(edge_q[2*i +: 2]))
            tpic_pkg::TPIC_EDGE_RISE: cap_ev[i] = rise; // [RULE12]
            tpic_pkg::TPIC_EDGE_FALL: cap_ev[i] = fall;
            tpic_pkg::TPIC_EDGE_BOTH: cap_ev[i] = rise || fall;
            default: cap_ev[i] = 1'b0;
         endcase
         cap_ev[i] = cap_ev[i] && !dir_q[i]; // [RULE3]
      end
   end

   // Capture registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NCH; i++) begin
            cap_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap_ev[i]) begin
               cap_q[i] <= count_q; // [RULE4]
            end
         end
      end
   end

   // Low byte view held after high read
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         low_hold_q <= '0;
         for (int i = 0; i < NCH; i++) begin
            low_view_q[i] <= `TPIC_RST_BYTE;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (hi_rd[i]) begin
               low_hold_q[i] <= 1'b1; // [RULE5]
            end else if (ar_hs) begin
               low_hold_q[i] <= 1'b0;
            end
            if (!low_hold_q[i] && !hi_rd[i]) begin
               low_view_q[i] <= cap_ev[i] ? count_q[7:0] : cap_q[i][7:0]; // [RULE5]
            end
         end
      end
   end

   // Read decode
   always_comb begin
      rd.data = 32'h00000000;
      rd.resp = `TPIC_RESP_OKAY;
      rd_clr = '0;
      hi_rd = '0;
      case (s_axi_araddr[6:5])
         2'h0: begin
            case (s_axi_araddr)
               `TPIC_OFS_CTRL: rd.data[4:0] = ctrl_q;
               `TPIC_OFS_DIR: rd.data[NCH-1:0] = dir_q;
               `TPIC_OFS_EDGE: rd.data[2*NCH-1:0] = edge_q;
               `TPIC_OFS_DDR: rd.data[NCH-1:0] = ddr_q;
               `TPIC_OFS_DATA: rd.data[NCH-1:0] = src;
               `TPIC_OFS_FLAG: begin
                  rd.data[NCH-1:0] = flag_q;
                  rd_clr = flag_q;
               end
               `TPIC_OFS_IEN: rd.data[NCH-1:0] = ien_q;
               `TPIC_OFS_COUNT: rd.data[CW-1:0] = count_q;
               default: rd.resp = `TPIC_RESP_SLVERR;
            endcase
         end
         2'h1: begin
            rd.data[CW-1:0] = cap_q[rch];
            rd_clr[rch] = ctrl_q.ffca; // [RULE13]
         end
         2'h2: begin
            rd.data[7:0] = cap_q[rch][15:8];
            rd_clr[rch] = ctrl_q.ffca; // [RULE13]
            hi_rd[rch] = ar_hs;
         end
         default: begin
            rd.data[7:0] = low_view_q[rch]; // [RULE5]
            rd_clr[rch] = ctrl_q.ffca; // [RULE13]
         end
      endcase
      if (s_axi_araddr[7]) begin
         rd.data = 32'h00000000;
         rd.resp = `TPIC_RESP_SLVERR;
         rd_clr = '0;
         hi_rd = '0;
      end
   end

   // Event flags, set wins over clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap_ev[i]) begin
               flag_q[i] <= 1'b1; // [RULE10]
            end else if (ar_hs && rd_clr[i]) begin
               flag_q[i] <= 1'b0; // [RULE13]
            end
         end
      end
   end

   // Interrupt
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flag_q & ien_q); // [RULE11]
      end
   end

   // Pin drive follows port direction and data registers only
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= data_q;
         pin_oe <= ddr_q; // [RULE7]
      end
   end

   // Write address and data capture
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !aw_hs && !wr_go;
         s_axi_wready <= !w_have_q && !w_hs && !wr_go;
         if (aw_hs) begin
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (w_hs) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Register writes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `TPIC_RST_CTRL;
         dir_q <= `TPIC_RST_BYTE;
         edge_q <= `TPIC_RST_EDGE; // [RULE12]
         ddr_q <= `TPIC_RST_BYTE;
         data_q <= `TPIC_RST_BYTE;
         ien_q <= `TPIC_RST_BYTE;
      end else if (wr_go) begin
         case (waddr_q)
            `TPIC_OFS_CTRL: begin
               if (wstrb_q[0]) begin
                  ctrl_q <= merged[4:0];
               end
            end
            `TPIC_OFS_DIR: dir_q <= m_dir[NCH-1:0];
            `TPIC_OFS_EDGE: edge_q <= m_edge[2*NCH-1:0];
            `TPIC_OFS_DDR: ddr_q <= m_ddr[NCH-1:0]; // [RULE7]
            `TPIC_OFS_DATA: data_q <= m_data[NCH-1:0];
            `TPIC_OFS_IEN: ien_q <= m_ien[NCH-1:0];
            default: begin
            end
         endcase
      end
   end

   // Write response
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TPIC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (waddr_q)
            `TPIC_OFS_CTRL, `TPIC_OFS_DIR, `TPIC_OFS_EDGE, `TPIC_OFS_DDR,
            `TPIC_OFS_DATA, `TPIC_OFS_IEN, `TPIC_OFS_FLAG, `TPIC_OFS_COUNT:
               s_axi_bresp <= `TPIC_RESP_OKAY;
            default: s_axi_bresp <= `TPIC_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TPIC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_hs;
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd.data;
            s_axi_rresp <= rd.resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ==== test/tpic_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tpic_pin_model (
   input wire logic clock,
   output logic [7:0] pins
);
   initial pins = 8'h00;
   // New level, held w clocks, w of 3 or more
   task automatic drive(logic [7:0] v, int w);
      pins <= v;
      repeat (w) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ==== test/tpic_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module tpic_checker #(
   parameter int NCH = 8,
   parameter int CW = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] cap_pin,
   input wire logic [NCH-1:0] pin_out,
   input wire logic [NCH-1:0] pin_oe,
   input wire logic irq
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   logic [NCH-1:0] pin_q;
   logic [3:0] quiet_q;
   // Cycles with no bus traffic and steady pins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= '0;
         quiet_q <= 4'h0;
      end else begin
         pin_q <= cap_pin;
         if (s_axi_arvalid || s_axi_awvalid || s_axi_wvalid || s_axi_rvalid || s_axi_bvalid || cap_pin != pin_q)
            quiet_q <= 4'h0;
         else if (quiet_q != 4'hF)
            quiet_q <= quiet_q + 4'h1;
      end
   end
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read late");
   chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read overlap");
   chk_arready_back: assert property (s_axi_rvalid && s_axi_rready |-> ##[1:2] s_axi_arready)
      else $error("arready stuck");
   chk_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("refused data");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write late");
   chk_bvalid_pulse: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   chk_pin_by_write: assert property ($changed(pin_oe) || $changed(pin_out)
      |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("pin drive moved");
   chk_irq_quiet: assert property (quiet_q >= 4'hA |-> $stable(irq))
      else $error("irq moved idle");
endmodule
bind tpic_top tpic_checker #(.NCH(NCH), .CW(CW)) u_chk (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .cap_pin, .pin_out, .pin_oe, .irq);
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [7:0] pin_out, pin_oe, ext, cap_pin;
   int n_errors = 0, num_checks = 0, cyc = 0, tk, t0, k, i, e, r, p, c, d, dv;
   int md[8];
   logic [31:0] rd, ev, ef, cv, wa;
   logic [1:0] rs;
   logic [7:0] h;
   bit ok;
   always #20 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   // Pin level seen by both parties
   assign cap_pin = (pin_oe & pin_out) | (~pin_oe & ext);
   tpic_pin_model pm (.clock, .pins(ext));
   tpic_top dut (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cap_pin, .pin_out, .pin_oe, .irq);
   function automatic bit hit(int m, int x);
      return m == 3 || (m == 1 && x == 1) || (m == 2 && x == 0);
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
      num_checks++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, x, s);
      end
   endtask
   task automatic hang;
      n_errors++;
      $display("[ERR] handshake exp answer got none");
      final_report();
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] x);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 99; k++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      if (k == 99) hang();
   endtask
   task automatic rdr(logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 99; k++) begin
         @(posedge clock);
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arvalid <= 1'b0;
            tk = cyc;
         end
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (k == 99) hang();
   endtask
   task automatic settle;
      repeat (8) @(posedge clock);
   endtask
   initial begin
      void'($urandom(32'h3560));
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rdr(8'h00);
      chk("ctrl reset", 32'h0, rd);
      rdr(8'h08);
      chk("edge reset", 32'h0, rd);
      rdr(8'h84);
      chk("unmapped", 32'h2, rd | 32'(rs));
      wr(8'h84, 32'hFF);
      chk("bad write", 32'h2, 32'(rs));
      for (p = 0; p < 9; p++) begin
         wr(8'h00, p < 8 ? 32'(p * 4 + 1) : 32'h0);
         rdr(8'h1C);
         cv = rd;
         t0 = tk;
         repeat (40 + $urandom % 64) @(posedge clock);
         rdr(8'h1C);
         dv = p < 8 ? 1 << (p > 5 ? 5 : p) : 0;
         d = int'((rd - cv) & 32'hFFFF);
         ok = p < 8 ? d * dv > tk - t0 - dv && d * dv < tk - t0 + dv : d == 0;
         chk("tick rate", 32'h1, 32'(ok));
      end
      r = $urandom % 4;
      ev = 32'h0;
      ef = 32'h0;
      for (i = 0; i < 8; i++) begin
         md[i] = (i + r) % 4;
         ev |= 32'(md[i] << (2 * i));
      end
      c = (7 - r) % 4;
      wr(8'h08, ev);
      chk("edge resp", 32'h0, 32'(rs));
      wr(8'h04, 32'h80);
      chk("oe", 32'h0, 32'(pin_oe));
      rdr(8'h1C);
      cv = rd;
      for (e = 1; e >= 0; e--) begin
         pm.drive(e ? 8'hFF : 8'h00, 3 + $urandom % 4);
         settle();
         for (i = 0; i < 8; i++) ef[i] = i < 7 && hit(md[i], e);
         rdr(8'h14);
         chk("flags", ef, rd);
      end
      rdr(8'(8'h20 + 4 * c));
      chk("capture", cv, rd);
      wr(8'h18, 32'h0);
      pm.drive(8'hFF, 3);
      settle();
      for (i = 0; i < 8; i++) ef[i] = i < 7 && hit(md[i], 1);
      chk("irq off", 32'h0, 32'(irq));
      wr(8'h18, ~ef & 32'hFF);
      repeat (2) @(posedge clock);
      chk("irq masked", 32'h0, 32'(irq));
      wr(8'h18, 32'hFF);
      repeat (2) @(posedge clock);
      chk("irq on", 32'h1, 32'(irq));
      wr(8'h00, 32'h2);
      rdr(8'(8'h60 + 4 * c));
      rdr(8'h14);
      chk("fast clear", ef & ~(32'h1 << c), rd);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(8'h00, 32'h1);
      pm.drive(8'h00, 3);
      settle();
      rdr(8'(8'h20 + 4 * c));
      wa = rd;
      rdr(8'(8'h40 + 4 * c));
      h = rd[7:0];
      pm.drive(8'hFF, 4);
      settle();
      rdr(8'(8'h60 + 4 * c));
      chk("held low", wa & 32'hFFFF, {h, rd[7:0]});
      rdr(8'(8'h20 + 4 * c));
      wa = rd;
      rdr(8'(8'h60 + 4 * c));
      chk("low view", wa & 32'hFF, rd);
      wr(8'h10, 32'h40);
      wr(8'h0C, 32'h40);
      wr(8'h08, ev | 32'h3000);
      rdr(8'h14);
      wr(8'h10, 32'h0);
      settle();
      chk("oe", 32'h40, 32'(pin_oe));
      chk("out", 32'h0, 32'(pin_out));
      rdr(8'h14);
      chk("sw capture", 32'h40, rd);
      final_report();
   end
endmodule
`default_nettype wire
